// ===== src/obc_params.svh
// Purpose: Offsets, field positions and reset values of the option loader.
// Assumes: Included by bare name from the design module only.
// Notes:   Definitions only.
`ifndef OBC_PARAMS_SVH
`define OBC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OBC_OFS_STATUS   32'h0000_0000
`define OBC_OFS_CONTROL  32'h0000_0004

// ----------------------------------------------------------------------
// Option byte field positions
// ----------------------------------------------------------------------
`define OBC_OB_SRC_LSB   0
`define OBC_OB_SRC_MSB   1
`define OBC_OB_NOSTOP    2
`define OBC_OB_WAIT_LSB  3
`define OBC_OB_WAIT_MSB  4

// ----------------------------------------------------------------------
// Reset values and AXI responses
// ----------------------------------------------------------------------
`define OBC_OB_RESET     8'h00
`define OBC_CTRL_RESET   2'h0
`define OBC_RESP_OKAY    2'h0
`define OBC_RESP_SLVERR  2'h2

`endif

// ===== src/obc_pkg.sv
// Purpose: Types of the option byte reset configuration block.
// Assumes: obc_params.svh holds the numeric constants.
// Notes:   Nothing here is imported; users write obc_pkg::name.
package obc_pkg;

   // Loader sequence states.
   typedef enum logic [1:0] {
      OBC_HOLD  = 2'b00,
      OBC_FETCH = 2'b01,
      OBC_WAIT  = 2'b10,
      OBC_RUN   = 2'b11
   } obc_state_t;

   // System clock source codes held in the option byte.
   typedef enum logic [1:0] {
      OBC_SRC_HSINT = 2'b00,
      OBC_SRC_XTAL  = 2'b01,
      OBC_SRC_EXT   = 2'b10,
      OBC_SRC_RSVD  = 2'b11
   } obc_src_t;

   // Watchdog count clock selections.
   typedef enum logic [1:0] {
      OBC_WDT_LSOSC = 2'b00,
      OBC_WDT_SYS   = 2'b01,
      OBC_WDT_DIV   = 2'b10,
      OBC_WDT_OFF   = 2'b11
   } obc_wdt_t;

endpackage : obc_pkg

// ===== src/obc_loader.sv
// Purpose: Reads the option byte after reset release and applies it.
// Assumes: All inputs synchronous to core_clk_i; option storage answers
//          a request with a one-cycle acknowledge carrying the byte.
// Notes:   Registers reached over AXI4-Lite.
// Behaviour
// RULE_01 - Stabilization wait applies only when crystal oscillator is chosen.
// RULE_02 - Internal or external clock source starts without stabilization wait.
// RULE_03 - Option byte is fetched only after reset condition has ended.
// RULE_04 - External reset low before the byte is read keeps device reset.
// RULE_05 - Crystal source gives both oscillator pins to clock, ports disabled.
// RULE_06 - External clock uses first oscillator pin, its port disabled.
// RULE_07 - Internal oscillator source frees both oscillator pins as ports.
// RULE_08 - Non-stoppable low-speed oscillator forces watchdog clock to it.
// RULE_09 - Decoded settings latch once per reset release, held until reset.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`include "obc_params.svh"
`timescale 1ns/100ps
`default_nettype none

module obc_loader #(
   parameter int unsigned WAIT0_CYC = 1024,
   parameter int unsigned WAIT1_CYC = 4096,
   parameter int unsigned WAIT2_CYC = 16384,
   parameter int unsigned WAIT3_CYC = 65536
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ext_reset_n_i,
   output var  logic        ob_req_o,
   input  wire logic        ob_ack_i,
   input  wire logic [7:0]  ob_data_i,
   output var  logic        cpu_reset_n_o,
   output var  logic        osc_pin_in_clk_en_o,
   output var  logic        osc_pin_out_clk_en_o,
   output var  logic        port_pin_first_osc_en_o,
   output var  logic        port_pin_second_osc_en_o,
   output var  logic [1:0]  watchdog_timer_clk_sel_o,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // Maps the option wait field to a cycle count.
   function automatic logic [16:0] wait_cycles(input logic [1:0] sel);
      case (sel)
         2'h0:    wait_cycles = 17'(WAIT0_CYC - 1);
         2'h1:    wait_cycles = 17'(WAIT1_CYC - 1);
         2'h2:    wait_cycles = 17'(WAIT2_CYC - 1);
         default: wait_cycles = 17'(WAIT3_CYC - 1);
      endcase
   endfunction : wait_cycles

   // -------------------------------------------------------------------
   // Loader sequence
   // -------------------------------------------------------------------
   obc_pkg::obc_state_t state_reg;
   obc_pkg::obc_state_t state_next;
   logic [7:0]          ob_reg;
   logic [7:0]          ob_next;
   logic [16:0]         cnt_reg;
   logic [16:0]         cnt_next;
   logic                take_ob;
   obc_pkg::obc_src_t   new_src;

   // A byte that meets a low reset pin is dropped and fetched again.
   assign take_ob = (state_reg == obc_pkg::OBC_FETCH) && ob_ack_i
                    && ext_reset_n_i;
   assign new_src = obc_pkg::obc_src_t'(
                       ob_data_i[`OBC_OB_SRC_MSB:`OBC_OB_SRC_LSB]);
   // The byte is captured only at the fetch of each release. [RULE_09]
   assign ob_next = take_ob ? ob_data_i : ob_reg;

   // Next state; a low reset pin always falls back to hold. [RULE_04]
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         obc_pkg::OBC_HOLD:
            if (ext_reset_n_i)
            begin
               state_next = obc_pkg::OBC_FETCH; // [RULE_03]
            end
         obc_pkg::OBC_FETCH:
            if (ob_ack_i && new_src == obc_pkg::OBC_SRC_XTAL)
            begin
               state_next = obc_pkg::OBC_WAIT; // [RULE_01]
               cnt_next   = wait_cycles(
                  ob_data_i[`OBC_OB_WAIT_MSB:`OBC_OB_WAIT_LSB]);
            end
            else if (ob_ack_i)
            begin
               state_next = obc_pkg::OBC_RUN; // [RULE_02]
            end
         obc_pkg::OBC_WAIT:
            if (cnt_reg == 17'h0_0000)
            begin
               state_next = obc_pkg::OBC_RUN;
            end
            else
            begin
               cnt_next = cnt_reg - 17'h0_0001;
            end
         default:
            state_next = obc_pkg::OBC_RUN;
      endcase
      if (!ext_reset_n_i)
      begin
         state_next = obc_pkg::OBC_HOLD; // [RULE_04]
      end
   end

   // Pin functions and watchdog clock decoded from the next byte.
   obc_pkg::obc_src_t src_next;
   logic              nostop_next;
   logic [1:0]        ctrl_reg;
   logic [1:0]        wdt_next;
   assign src_next    = obc_pkg::obc_src_t'(
                           ob_next[`OBC_OB_SRC_MSB:`OBC_OB_SRC_LSB]);
   assign nostop_next = ob_next[`OBC_OB_NOSTOP];
   // Non-stoppable oscillator overrides software choice. [RULE_08]
   assign wdt_next    = nostop_next ? obc_pkg::OBC_WDT_LSOSC : ctrl_reg;

   // Sequence registers.
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg     <= obc_pkg::OBC_HOLD;
         ob_reg        <= `OBC_OB_RESET;
         cnt_reg       <= 17'h0_0000;
         cpu_reset_n_o <= 1'b0;
         ob_req_o      <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         ob_reg        <= ob_next; // [RULE_09]
         cnt_reg       <= cnt_next;
         cpu_reset_n_o <= (state_next == obc_pkg::OBC_RUN); // [RULE_04]
         ob_req_o      <= (state_next == obc_pkg::OBC_FETCH); // [RULE_03]
      end
   end

   // Pin function outputs track the latched byte in the same edge.
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         osc_pin_in_clk_en_o      <= 1'b0;
         osc_pin_out_clk_en_o     <= 1'b0;
         port_pin_first_osc_en_o  <= 1'b1;
         port_pin_second_osc_en_o <= 1'b1;
         watchdog_timer_clk_sel_o <= obc_pkg::OBC_WDT_LSOSC;
      end
      else
      begin
         // Crystal takes both pins, external clock the first. [RULE_05]
         // External clock takes only the first pin. [RULE_06]
         // Internal oscillator leaves both pins to the ports. [RULE_07]
         osc_pin_in_clk_en_o      <= (src_next == obc_pkg::OBC_SRC_XTAL)
                                     || (src_next == obc_pkg::OBC_SRC_EXT);
         osc_pin_out_clk_en_o     <= (src_next == obc_pkg::OBC_SRC_XTAL);
         port_pin_first_osc_en_o  <= (src_next != obc_pkg::OBC_SRC_XTAL)
                                  && (src_next != obc_pkg::OBC_SRC_EXT);
         port_pin_second_osc_en_o <= (src_next != obc_pkg::OBC_SRC_XTAL);
         watchdog_timer_clk_sel_o <= wdt_next; // [RULE_08]
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite slave
   // -------------------------------------------------------------------
   logic        aw_have;
   logic        w_have;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic        wr_hit;
   logic        rd_ctrl;
   logic        rd_stat;
   logic [31:0] rd_data;

   assign do_write = aw_have && w_have && !s_axi_bvalid;
   assign wr_hit   = (aw_addr == `OBC_OFS_CONTROL)
                     || (aw_addr == `OBC_OFS_STATUS);
   assign rd_stat  = (s_axi_araddr == `OBC_OFS_STATUS);
   assign rd_ctrl  = (s_axi_araddr == `OBC_OFS_CONTROL);
   // Status shows state, latched byte and the running watchdog clock.
   assign rd_data  = rd_stat ? {20'h0_0000, watchdog_timer_clk_sel_o,
                                state_reg, ob_reg}
                   : rd_ctrl ? {30'h0000_0000, ctrl_reg}
                   : 32'h0000_0000;

   // Write channel: address and data taken in either order.
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         aw_addr       <= 32'h0000_0000;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `OBC_RESP_OKAY;
         ctrl_reg      <= `OBC_CTRL_RESET;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `OBC_RESP_OKAY : `OBC_RESP_SLVERR;
            if (aw_addr == `OBC_OFS_CONTROL && w_strb[0])
            begin
               ctrl_reg <= w_data[1:0];
            end
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Read channel: one cycle from address to data.
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `OBC_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= (rd_stat || rd_ctrl) ? `OBC_RESP_OKAY
                                               : `OBC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   sequence s_xtal_fetch;
      state_reg == obc_pkg::OBC_FETCH && ob_ack_i && ext_reset_n_i
      && new_src == obc_pkg::OBC_SRC_XTAL;
   endsequence

   sequence s_plain_fetch;
      state_reg == obc_pkg::OBC_FETCH && ob_ack_i && ext_reset_n_i
      && new_src != obc_pkg::OBC_SRC_XTAL;
   endsequence

   AST_XTAL_WAITS: assert property (@(posedge core_clk_i) // [RULE_01]
      disable iff (!rst_n_i)
      s_xtal_fetch |=> (state_reg == obc_pkg::OBC_WAIT) && !cpu_reset_n_o)
      else $error("Crystal source skipped the stabilization wait.");

   AST_NO_WAIT: assert property (@(posedge core_clk_i) // [RULE_02]
      disable iff (!rst_n_i)
      s_plain_fetch |=> cpu_reset_n_o && state_reg == obc_pkg::OBC_RUN)
      else $error("Non-crystal source did not start at once.");

   AST_FETCH_AFTER_RELEASE: assert property (@(posedge core_clk_i) // [RULE_03]
      disable iff (!rst_n_i)
      !ext_reset_n_i |=> !ob_req_o)
      else $error("Option byte requested while reset pin low.");

   AST_HOLD_RESET: assert property (@(posedge core_clk_i) // [RULE_04]
      disable iff (!rst_n_i)
      (!ext_reset_n_i && state_reg != obc_pkg::OBC_RUN) |=> !cpu_reset_n_o)
      else $error("Reset released with reset pin low.");

   AST_XTAL_PINS: assert property (@(posedge core_clk_i) // [RULE_05]
      disable iff (!rst_n_i)
      ob_reg[1:0] == obc_pkg::OBC_SRC_XTAL |-> osc_pin_in_clk_en_o
      && osc_pin_out_clk_en_o && !port_pin_first_osc_en_o
      && !port_pin_second_osc_en_o)
      else $error("Crystal source left a port function on.");

   AST_EXTCLK_PINS: assert property (@(posedge core_clk_i) // [RULE_06]
      disable iff (!rst_n_i)
      ob_reg[1:0] == obc_pkg::OBC_SRC_EXT |-> osc_pin_in_clk_en_o
      && !port_pin_first_osc_en_o && port_pin_second_osc_en_o)
      else $error("External clock pin mapping wrong.");

   AST_HSINT_PINS: assert property (@(posedge core_clk_i) // [RULE_07]
      disable iff (!rst_n_i)
      ob_reg[1:0] == obc_pkg::OBC_SRC_HSINT |-> port_pin_first_osc_en_o
      && port_pin_second_osc_en_o && !osc_pin_in_clk_en_o)
      else $error("Internal oscillator source kept oscillator pins.");

   AST_WDT_FORCED: assert property (@(posedge core_clk_i) // [RULE_08]
      disable iff (!rst_n_i)
      ob_reg[`OBC_OB_NOSTOP] |-> watchdog_timer_clk_sel_o
      == obc_pkg::OBC_WDT_LSOSC)
      else $error("Watchdog clock not forced to low-speed oscillator.");

   AST_HOLD_CFG: assert property (@(posedge core_clk_i) // [RULE_09]
      disable iff (!rst_n_i)
      state_reg != obc_pkg::OBC_FETCH |=> $stable(ob_reg))
      else $error("Option settings changed outside the fetch.");

endmodule : obc_loader
`default_nettype wire

// ===== tb/obc_store_model.sv
// Purpose: Option storage and external reset driver facing the loader.
// Assumes: Requests are levels; the answer is a one-cycle acknowledge.
// Notes:   Delay, byte and reset misuse are set by the bench.
`timescale 1ns/100ps
`default_nettype none

module obc_store_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       req_i,
   input  wire logic [7:0] byte_i,
   input  wire logic [3:0] delay_i,
   input  wire logic       pull_i,
   input  wire logic       early_i,
   output var  logic       ack_o,
   output var  logic [7:0] data_o,
   output var  logic       ext_reset_n_o
);
   logic [3:0] cnt_reg;
   logic       done_reg;

   // The reset pin stays high while a read is pending unless misuse is
   // commanded on purpose.
   assign ext_reset_n_o = !(pull_i || (early_i && req_i));

   // Answers each request once after a chosen delay; the idle bus toggles.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_reg  <= 4'h0;
         done_reg <= 1'h0;
         ack_o    <= 1'h0;
         data_o   <= 8'hA5;
      end
      else
      begin
         ack_o  <= 1'h0;
         data_o <= ~data_o;
         if (!req_i)
         begin
            cnt_reg  <= 4'h0;
            done_reg <= 1'h0;
         end
         else if (!done_reg && cnt_reg == delay_i)
         begin
            ack_o    <= 1'h1;
            data_o   <= byte_i;
            done_reg <= 1'h1;
         end
         else
            cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule : obc_store_model

`default_nettype wire

// ===== tb/test_option_byte_reset_config.sv
// Purpose: Self-checking bench of the option byte loader.
// Assumes: Short wait counts 4, 8, 16 and 32 cycles.
// Notes:   Registers are reached through AXI4-Lite tasks.
`timescale 1ns/100ps
`default_nettype none

module test_option_byte_reset_config;
   logic        core_clk_i = 1'h0, rst_n_i = 1'h0, pull = 1'h0;
   logic        early = 1'h0, ob_req_o, ob_ack_i, cpu_reset_n_o, ext_n;
   logic [7:0]  ob_data_i, byte_v = 8'h00;
   logic [3:0]  dly_v = 4'h0;
   logic        osc_pin_in_clk_en_o, osc_pin_out_clk_en_o;
   logic        port_pin_first_osc_en_o, port_pin_second_osc_en_o;
   logic [1:0]  watchdog_timer_clk_sel_o, s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata;
   logic [31:0] s_axi_araddr = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int          mismatches = 0, cmp_count = 0;

   always #25 core_clk_i = ~core_clk_i;

   obc_loader #(.WAIT0_CYC(4), .WAIT1_CYC(8), .WAIT2_CYC(16),
                .WAIT3_CYC(32)) uut (
      .core_clk_i, .rst_n_i, .ext_reset_n_i(ext_n), .ob_req_o, .ob_ack_i,
      .ob_data_i, .cpu_reset_n_o, .osc_pin_in_clk_en_o,
      .osc_pin_out_clk_en_o, .port_pin_first_osc_en_o,
      .port_pin_second_osc_en_o, .watchdog_timer_clk_sel_o,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   obc_store_model store (.clk_i(core_clk_i), .rst_n_i, .req_i(ob_req_o),
      .byte_i(byte_v), .delay_i(dly_v), .pull_i(pull), .early_i(early),
      .ack_o(ob_ack_i), .data_o(ob_data_i), .ext_reset_n_o(ext_n));

   // -------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------
   task report_and_stop;
      $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   task check(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : check

   task wr(input logic [31:0] a, input logic [31:0] d,
           input logic [3:0] st, input logic [1:0] er);
      int k;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      k = 0;
      do
      begin
         @(posedge core_clk_i);
         k++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid && k < 50);
      s_axi_bready <= 1'h0;
      check(s_axi_bvalid, 1'h1);
      check(s_axi_bresp, er);
      @(posedge core_clk_i);
   endtask : wr

   task rd(input logic [31:0] a, input logic [31:0] ed,
           input logic [1:0] er);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      k = 0;
      do
      begin
         @(posedge core_clk_i);
         k++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid && k < 50);
      s_axi_rready <= 1'h0;
      check(s_axi_rvalid, 1'h1);
      check(s_axi_rdata, ed);
      check(s_axi_rresp, er);
      @(posedge core_clk_i);
   endtask : rd

   // Counts edges until the core leaves reset, bounded.
   task wait_run(output int n);
      n = 0;
      while (cpu_reset_n_o !== 1'h1 && n < 200)
      begin
         @(posedge core_clk_i);
         n++;
      end
   endtask : wait_run

   // Resets, then counts edges from the taken acknowledge to run.
   task boot(input logic [7:0] b, input logic [3:0] dl, output int n);
      int k;
      byte_v <= b;
      dly_v <= dl;
      rst_n_i <= 1'h0;
      repeat (4) @(posedge core_clk_i);
      check(ob_req_o, 1'h0);
      rst_n_i <= 1'h1;
      k = 0;
      while (!(ob_req_o && ob_ack_i) && k < 100)
      begin
         @(posedge core_clk_i);
         k++;
      end
      wait_run(n);
   endtask : boot

   task pins(input logic [1:0] s);
      check(osc_pin_in_clk_en_o, s == 2'h1 || s == 2'h2);
      check(osc_pin_out_clk_en_o, s == 2'h1);
      check(port_pin_first_osc_en_o, s == 2'h0 || s == 2'h3);
      check(port_pin_second_osc_en_o, s != 2'h1);
   endtask : pins

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task t_sources;
      int n, w[4];
      logic [7:0] b;
      w = '{4, 8, 16, 32};
      for (int s = 0; s < 4; s++)
         for (int q = 0; q < 4; q++)
         begin
            b = {3'h0, q[1:0], 1'h0, s[1:0]};
            boot(b, q[3:0], n);
            if (s == 1)
               check(n, w[q] + 1);
            else
               check(n, 1);
            pins(s[1:0]);
         end
   endtask : t_sources

   task t_regs;
      int n;
      boot(8'h0A, 4'h1, n);
      check(n, 1);
      wr(32'h4, 32'h2, 4'hF, 2'h0);
      repeat (2) @(posedge core_clk_i);
      check(watchdog_timer_clk_sel_o, 2'h2);
      rd(32'h4, 32'h2, 2'h0);
      rd(32'h0, {20'h0, 2'h2, 2'h3, 8'h0A}, 2'h0);
      wr(32'h0, 32'hFFF, 4'hF, 2'h0);
      wr(32'h8, 32'h1, 4'hF, 2'h2);
      rd(32'h8, 32'h0, 2'h2);
      wr(32'h4, 32'h1, 4'h0, 2'h0);
      rd(32'h4, 32'h2, 2'h0);
      rd(32'h0, {20'h0, 2'h2, 2'h3, 8'h0A}, 2'h0);
      pins(2'h2);
   endtask : t_regs

   task t_nostop;
      int n;
      boot(8'h04, 4'h0, n);
      check(n, 1);
      wr(32'h4, 32'h3, 4'hF, 2'h0);
      repeat (2) @(posedge core_clk_i);
      check(watchdog_timer_clk_sel_o, 2'h0);
   endtask : t_nostop

   task t_early;
      int n;
      early <= 1'h1;
      boot(8'h00, 4'h2, n);
      check(cpu_reset_n_o, 1'h0);
      early <= 1'h0;
      wait_run(n);
      check(cpu_reset_n_o, 1'h1);
      pull <= 1'h1;
      repeat (3) @(posedge core_clk_i);
      check(cpu_reset_n_o, 1'h0);
      pull <= 1'h0;
      wait_run(n);
      check(cpu_reset_n_o, 1'h1);
   endtask : t_early

   // Watchdog that cuts a hang short.
   initial
   begin
      #2000000;
      mismatches++;
      report_and_stop;
   end

   // Main sequence.
   initial
   begin
      t_sources;
      t_regs;
      t_nostop;
      t_early;
      report_and_stop;
   end
endmodule : test_option_byte_reset_config

`default_nettype wire
